//--- rtl/reset_clock_strap_config.sv
// Purpose: System reset, derived clocks and power-on strap latches
// Assumes: clk is the PLL (or bypass) system clock
// Notes: PLL itself is an analog macro outside; we drive its settings
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Reference clock feeds PLL producing the system clock; PLL is enabled here unless the bypass strap is high.
// - USB and parallel-port clocks each have their own gate enable.
// - 12 MHz USB clock is system clock divided by four.
// - Refresh tick every 48 system clock cycles.
// - Power-good input is active low and asynchronous.
// - Watchdog request gives a 200-cycle reset pulse.
// - Reset output released synchronously; USB 12 MHz domain resyncs itself.
// - PLL dividers fixed at 25, 48 and 1.
// - Address lines stay inputs and are sampled while power-good low.
// - Bypass and debug straps act before power-good rises.
// - Debug strap low switches shared pins to debug port.
// - Firmware strap register holds address lines 14 to 7, read only.
// - Memory-type strap from line 22: high SDRAM, low EDO.
// - Registers are 8 bits wide on 32-bit aligned words.
// - USB clock strap from line 21; low keeps USB clock stopped.
// - Parallel-port strap from line 20; low stops its clock.
// - Bypass strap from line 17; high selects external clock pin.
// - Debug enable strap from line 18; high keeps memory pin use.
module reset_clock_strap_config
   import rcg_pkg::*;
#(
   parameter int ADDR_W = 23
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic power_ok_reset_input_n,
   input wire logic watchdog_reset_request,
   input wire logic pll_locked,
   input wire logic [ADDR_W-1:0] address_in,
   output logic address_lines_input_only,
   output logic pll_enable,
   output logic [7:0] pll_pre_div,
   output logic [7:0] pll_fb_div,
   output logic [7:0] pll_post_div,
   output logic use_external_clock_input,
   output logic debug_port_mode,
   output logic sdram_select,
   output logic boot_bank_width_strap,
   output logic usb_clock_enable,
   output logic parallel_port_clock_gate,
   output logic usb_12m_clock,
   output logic refresh_tick,
   output logic system_reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Word match on an aligned register address
   function automatic logic hit(input logic [31:0] a,
                                input logic [31:0] off);
      hit = (a[31:2] == off[31:2]);
   endfunction

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic por_async;
   logic pg_meta_r;
   logic pg_sync_r;
   logic [7:0] fw_strap_r;
   logic [7:0] hw_strap_r;
   logic bypass_now;
   logic debug_en_now;
   logic [7:0] gate_ctrl_r;
   seq_state_type seq_r;
   logic [7:0] wdog_cnt_r;
   logic int_reset;
   logic rst_out_r;
   logic [1:0] usb_div_r;
   logic usb_clk_r;
   logic [5:0] refresh_cnt_r;
   logic refresh_r;
   logic ap_write_r;
   logic [31:0] ap_addr_r;
   logic [31:0] hrdata_r;
   logic ap_take;
   logic [31:0] rd_value;
   rst_sync_if rsi ();

   // Power-on reset: bench reset or power-good low
   assign por_async = reset | ~power_ok_reset_input_n;

   // ------------------------------------------------------------
   // Power-good synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge por_async) begin
      if (por_async) begin
         pg_meta_r <= 1'b0;
         pg_sync_r <= 1'b0;
      end else begin
         pg_meta_r <= 1'b1;
         pg_sync_r <= pg_meta_r;
      end
   end

   // ------------------------------------------------------------
   // Strap capture
   // ------------------------------------------------------------
   // Sampled each cycle until power-good release settles
   always_ff @(posedge clk) begin
      if (!pg_sync_r) begin
         fw_strap_r <= address_in[FW_LINE_LO+7:FW_LINE_LO];
         hw_strap_r <= {address_in[MEM_TYPE_LINE],
                        address_in[USB_CLK_LINE],
                        address_in[PPORT_LINE],
                        address_in[BOOT_WIDTH_LINE],
                        address_in[DEBUG_EN_LINE],
                        address_in[BYPASS_LINE],
                        2'b00};
      end
   end

   // Address pads kept as inputs during power-on reset
   assign address_lines_input_only = ~pg_sync_r;

   // Early straps follow the pins until the latch has closed
   assign bypass_now = pg_sync_r ? hw_strap_r[2]
                                 : address_in[BYPASS_LINE];
   assign debug_en_now = pg_sync_r ? hw_strap_r[3]
                                   : address_in[DEBUG_EN_LINE];

   // ------------------------------------------------------------
   // PLL settings and clock selection
   // ------------------------------------------------------------
   assign pll_enable = ~bypass_now;
   assign pll_pre_div = PLL_PRE_DIV;
   assign pll_fb_div = PLL_FB_DIV;
   assign pll_post_div = PLL_POST_DIV;
   assign use_external_clock_input = bypass_now;
   assign debug_port_mode = ~debug_en_now;
   assign sdram_select = hw_strap_r[7];
   assign boot_bank_width_strap = hw_strap_r[4];

   // ------------------------------------------------------------
   // Reset sequencer
   // ------------------------------------------------------------
   // Hold for lock, run, then stretch watchdog requests
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         seq_r <= SEQ_HOLD;
         wdog_cnt_r <= 8'h00;
      end else begin
         case (seq_r)
            SEQ_HOLD: begin
               if (pg_sync_r) begin
                  seq_r <= SEQ_WAIT_LOCK;
               end
            end
            SEQ_WAIT_LOCK: begin
               if (pll_locked || bypass_now) begin
                  seq_r <= SEQ_RUN;
               end
            end
            SEQ_RUN: begin
               if (!pg_sync_r) begin
                  seq_r <= SEQ_HOLD;
               end else if (watchdog_reset_request) begin
                  seq_r <= SEQ_WDOG;
                  wdog_cnt_r <= 8'(WDOG_PULSE_CYCLES - 1);
               end
            end
            SEQ_WDOG: begin
               if (!pg_sync_r) begin
                  seq_r <= SEQ_HOLD;
               end else if (wdog_cnt_r == 8'h00) begin
                  seq_r <= SEQ_RUN;
               end else begin
                  wdog_cnt_r <= wdog_cnt_r - 8'h01;
               end
            end
            default: begin
               seq_r <= SEQ_HOLD;
            end
         endcase
      end
   end

   // Internal reset request for the synchroniser
   assign int_reset = por_async | (seq_r != SEQ_RUN);
   assign rsi.async_req = int_reset;

   // Synchronous release onto the system clock
   rst_synchronizer u_rst_sync (
      .clk (clk),
      .rs (rsi.sync)
   );

   // Output reset from a flop so it never glitches
   always_ff @(posedge clk or posedge por_async) begin
      if (por_async) begin
         rst_out_r <= 1'b1;
      end else begin
         rst_out_r <= rsi.sync_rst;
      end
   end

   assign system_reset = rst_out_r;

   // ------------------------------------------------------------
   // Derived clocks and refresh tick
   // ------------------------------------------------------------
   // Divide by four: toggle every second cycle
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         usb_div_r <= 2'b00;
         usb_clk_r <= 1'b0;
      end else begin
         usb_div_r <= usb_div_r + 2'b01;
         if (usb_div_r[0]) begin
            usb_clk_r <= ~usb_clk_r;
         end
      end
   end

   assign usb_12m_clock = usb_clk_r;

   // One-cycle refresh pulse every REFRESH_DIV cycles
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         refresh_cnt_r <= 6'h00;
         refresh_r <= 1'b0;
      end else if (refresh_cnt_r == 6'(REFRESH_DIV - 1)) begin
         refresh_cnt_r <= 6'h00;
         refresh_r <= 1'b1;
      end else begin
         refresh_cnt_r <= refresh_cnt_r + 6'h01;
         refresh_r <= 1'b0;
      end
   end

   assign refresh_tick = refresh_r;

   // Gate enables: software bit and strap must both allow
   assign usb_clock_enable = gate_ctrl_r[GATE_USB_BIT]
                             & hw_strap_r[6] & pg_sync_r;
   assign parallel_port_clock_gate = gate_ctrl_r[GATE_PPORT_BIT]
                                     & hw_strap_r[5] & pg_sync_r;

   // ------------------------------------------------------------
   // AHB-Lite slave
   // ------------------------------------------------------------
   assign ap_take = hsel & htrans[1] & hready;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Read mux, 8-bit registers in the low byte
   always_comb begin
      rd_value = 32'h0000_0000;
      if (hit(haddr, FW_STRAP_ADDR)) begin
         rd_value[7:0] = fw_strap_r;
      end else if (hit(haddr, HW_STRAP_ADDR)) begin
         rd_value[7:0] = hw_strap_r;
      end else if (hit(haddr, STATUS_ADDR)) begin
         rd_value[STAT_LOCK_BIT] = pll_locked;
         rd_value[STAT_BYPASS_BIT] = bypass_now;
         rd_value[STAT_WDOG_BIT] = (seq_r == SEQ_WDOG);
      end else if (hit(haddr, GATE_CTRL_ADDR)) begin
         rd_value[7:0] = gate_ctrl_r;
      end
   end

   // Address phase capture and registered read data
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ap_write_r <= 1'b0;
         ap_addr_r <= 32'h0000_0000;
         hrdata_r <= 32'h0000_0000;
      end else begin
         if (hready) begin
            ap_write_r <= ap_take & hwrite;
            ap_addr_r <= haddr;
         end
         if (ap_take && !hwrite) begin
            hrdata_r <= rd_value;
         end
      end
   end

   assign hrdata = hrdata_r;

   // Gate control register, written in the data phase
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         gate_ctrl_r <= GATE_CTRL_RESET;
      end else if (ap_write_r && hit(ap_addr_r, GATE_CTRL_ADDR)) begin
         gate_ctrl_r <= {6'b000000, hwdata[1:0]};
      end
   end

endmodule
`default_nettype wire

//--- rtl/rcg_pkg.sv
// Purpose: Constants for the reset, clock and strap block
// Assumes: 32-bit word-aligned AHB-Lite register map
// Notes: Offsets are full byte addresses
package rcg_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [31:0] FW_STRAP_ADDR = 32'h3000_1C00;
   localparam logic [31:0] HW_STRAP_ADDR = 32'h3000_1C04;
   localparam logic [31:0] STATUS_ADDR = 32'h3000_1C0C;
   localparam logic [31:0] GATE_CTRL_ADDR = 32'h3000_1C18;
   localparam logic [7:0] GATE_CTRL_RESET = 8'h03;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int FW_LINE_LO = 7;
   localparam int MEM_TYPE_LINE = 22;
   localparam int USB_CLK_LINE = 21;
   localparam int PPORT_LINE = 20;
   localparam int BOOT_WIDTH_LINE = 19;
   localparam int DEBUG_EN_LINE = 18;
   localparam int BYPASS_LINE = 17;
   localparam int GATE_USB_BIT = 0;
   localparam int GATE_PPORT_BIT = 1;
   localparam int STAT_LOCK_BIT = 0;
   localparam int STAT_BYPASS_BIT = 1;
   localparam int STAT_WDOG_BIT = 2;

   // ------------------------------------------------------------
   // Dividers and counts, in system clock cycles
   // ------------------------------------------------------------
   localparam logic [7:0] PLL_PRE_DIV = 8'h19;
   localparam logic [7:0] PLL_FB_DIV = 8'h30;
   localparam logic [7:0] PLL_POST_DIV = 8'h01;
   localparam int USB_DIV = 4;
   localparam int REFRESH_DIV = 48;
   localparam int WDOG_PULSE_CYCLES = 200;

   // Reset sequencer states
   typedef enum logic [1:0] {
      SEQ_HOLD,
      SEQ_WAIT_LOCK,
      SEQ_RUN,
      SEQ_WDOG
   } seq_state_type;

endpackage

//--- rtl/rst_sync_if.sv
// Purpose: Carrier between the sequencer and the reset synchroniser
// Assumes: One clock
// Notes: Request is asynchronous, result is synchronous release
`timescale 1ns/1ps
`default_nettype none
interface rst_sync_if;
   logic async_req;
   logic sync_rst;
   modport src (output async_req, input sync_rst);
   modport sync (input async_req, output sync_rst);
endinterface
`default_nettype wire

//--- rtl/rst_synchronizer.sv
// Purpose: Reset with asynchronous assertion and synchronous release
// Assumes: async_req active high
// Notes: Two flip-flop release chain
`timescale 1ns/1ps
`default_nettype none
module rst_synchronizer (
   input wire logic clk,
   rst_sync_if.sync rs
);
   logic meta_r;
   logic hold_r;

   // ------------------------------------------------------------
   // Release chain
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge rs.async_req) begin
      if (rs.async_req) begin
         meta_r <= 1'b1;
         hold_r <= 1'b1;
      end else begin
         meta_r <= 1'b0;
         hold_r <= meta_r;
      end
   end

   assign rs.sync_rst = hold_r;
endmodule
`default_nettype wire

//--- test/rcg_properties.sv
// Purpose: Assertions on reset, divider and strap outputs
// Assumes: One clock domain, reset active high
// Notes: Bound to the top module at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module rcg_properties #(
   parameter int ADDR_W = 23
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic power_ok_reset_input_n,
   input wire logic watchdog_reset_request,
   input wire logic [ADDR_W-1:0] address_in,
   input wire logic address_lines_input_only,
   input wire logic [7:0] pll_pre_div,
   input wire logic [7:0] pll_fb_div,
   input wire logic [7:0] pll_post_div,
   input wire logic use_external_clock_input,
   input wire logic debug_port_mode,
   input wire logic sdram_select,
   input wire logic boot_bank_width_strap,
   input wire logic usb_12m_clock,
   input wire logic refresh_tick,
   input wire logic system_reset,
   input wire logic hreadyout,
   input wire logic hresp
);
   logic [7:0] gap_r;
   logic tick_seen_r;
   logic [8:0] high_r;
   logic wdog_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // Cycles since the last refresh tick
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         gap_r <= 8'h00;
         tick_seen_r <= 1'b0;
      end else begin
         gap_r <= refresh_tick ? 8'h00 : gap_r + 8'h01;
         tick_seen_r <= tick_seen_r | refresh_tick;
      end
   end
   // Length of the current reset pulse, saturating
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         high_r <= 9'h000;
      end else if (!system_reset) begin
         high_r <= 9'h000;
      end else if (high_r != 9'h1FF) begin
         high_r <= high_r + 9'h001;
      end
   end
   // Marks a pulse started by the watchdog while running
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wdog_r <= 1'b0;
      end else if (!power_ok_reset_input_n) begin
         wdog_r <= 1'b0;
      end else if (watchdog_reset_request && !system_reset) begin
         wdog_r <= 1'b1;
      end else if (!system_reset && high_r != 9'h000) begin
         wdog_r <= 1'b0;
      end
   end
   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus slave not ready or not okay");
   chk_pll_setting: assert property (
      pll_pre_div == 8'h19 && pll_fb_div == 8'h30 && pll_post_div == 8'h01)
      else $error("pll divider setting wrong");
   chk_pok_reset: assert property (!power_ok_reset_input_n |-> system_reset)
      else $error("reset output low while power-good low");
   chk_strap_input: assert property (
      !power_ok_reset_input_n |-> ##1 address_lines_input_only)
      else $error("address lines not inputs during strap sampling");
   chk_usb_divide: assert property (
      $changed(usb_12m_clock) |=> $stable(usb_12m_clock) ##1 $changed(usb_12m_clock))
      else $error("usb clock not a divide by four");
   chk_refresh_gap: assert property (refresh_tick && tick_seen_r |-> gap_r == 8'h2F)
      else $error("refresh ticks not 48 cycles apart");
   chk_wdog_length: assert property (
      $fell(system_reset) && wdog_r |-> high_r >= 9'h0C8 && high_r <= 9'h0CE)
      else $error("watchdog reset pulse length wrong");
   chk_strap_hold: assert property (
      power_ok_reset_input_n [*5] |-> $stable(sdram_select) && $stable(boot_bank_width_strap))
      else $error("latched strap changed while power-good high");
   chk_live_straps: assert property (!power_ok_reset_input_n |->
      debug_port_mode == !address_in[18] && use_external_clock_input == address_in[17])
      else $error("bypass or debug strap not live during power-on");
endmodule
bind reset_clock_strap_config rcg_properties #(.ADDR_W(ADDR_W)) i_chk (
   .clk(clk), .reset(reset), .power_ok_reset_input_n(power_ok_reset_input_n),
   .watchdog_reset_request(watchdog_reset_request), .address_in(address_in),
   .address_lines_input_only(address_lines_input_only), .pll_pre_div(pll_pre_div),
   .pll_fb_div(pll_fb_div), .pll_post_div(pll_post_div),
   .use_external_clock_input(use_external_clock_input), .debug_port_mode(debug_port_mode),
   .sdram_select(sdram_select), .boot_bank_width_strap(boot_bank_width_strap),
   .usb_12m_clock(usb_12m_clock), .refresh_tick(refresh_tick),
   .system_reset(system_reset), .hreadyout(hreadyout), .hresp(hresp));
`default_nettype wire

//--- test/board_supervisor.sv
// Purpose: Board power supervisor and strap resistors
// Assumes: Straps hold until the address bus is driven after reset
// Notes: Lock comes midway through the power-good hold
`timescale 1ns/1ps
`default_nettype none
module board_supervisor #(
   parameter int HOLD_CYCLES = 24
) (
   input wire logic clk,
   input wire logic start,
   input wire logic [22:0] strap_value,
   input wire logic pll_enable,
   input wire logic system_reset,
   output logic power_ok_reset_input_n,
   output logic [22:0] address_in,
   output logic pll_locked,
   output logic busy
);
   int cnt = 0;
   logic pok_r = 1'b0;
   logic busy_r = 1'b1;
   logic lock_r = 1'b0;
   // Power-good held low until well after lock
   always @(posedge clk) begin
      if (start) begin
         pok_r <= 1'b0;
         busy_r <= 1'b1;
         cnt <= 0;
      end else if (busy_r) begin
         cnt <= cnt + 1;
         if (cnt == HOLD_CYCLES) begin
            pok_r <= 1'b1;
            busy_r <= 1'b0;
         end
      end
      lock_r <= pll_enable && (!busy_r || cnt > HOLD_CYCLES / 2);
   end
   assign power_ok_reset_input_n = pok_r;
   assign busy = busy_r;
   assign pll_locked = lock_r;
   // Weak straps until the bus is driven, then other traffic
   assign address_in = (pok_r && !system_reset) ? ~strap_value : strap_value;
endmodule
`default_nettype wire

//--- test/tb_top.sv
// Purpose: Self-checking bench for the reset, clock and strap block
// Assumes: Zero-wait AHB-Lite slave, 50 ns clock
// Notes: Two strap patterns cover both levels of every strap
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import rcg_pkg::*;
   localparam logic [22:0] STRAP_A = 23'h6C_5280;
   localparam logic [22:0] STRAP_B = 23'h13_AD7F;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic wdog_req = 1'b0;
   logic start = 1'b0;
   logic [22:0] strap = STRAP_A;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic pok_n, locked, sup_busy, in_only, pll_en, ext_clk, dbg_mode, sdram, boot_w;
   logic usb_en, pport_en, usb_12m, tick, sys_rst, hready, hresp, usb_prev;
   logic [22:0] addr;
   logic [31:0] hrdata, rd;
   int bad_count = 0;
   int checked = 0;
   int cycles = 0;
   int n = 0;
   int ticks = 0;
   int rises = 0;
   board_supervisor i_sup (.clk(clk), .start(start), .strap_value(strap), .pll_enable(pll_en),
      .system_reset(sys_rst), .power_ok_reset_input_n(pok_n), .address_in(addr),
      .pll_locked(locked), .busy(sup_busy));
   reset_clock_strap_config i_dut (.clk(clk), .reset(reset), .power_ok_reset_input_n(pok_n),
      .watchdog_reset_request(wdog_req), .pll_locked(locked), .address_in(addr),
      .address_lines_input_only(in_only), .pll_enable(pll_en), .pll_pre_div(),
      .pll_fb_div(), .pll_post_div(), .use_external_clock_input(ext_clk),
      .debug_port_mode(dbg_mode), .sdram_select(sdram), .boot_bank_width_strap(boot_w),
      .usb_clock_enable(usb_en), .parallel_port_clock_gate(pport_en),
      .usb_12m_clock(usb_12m), .refresh_tick(tick), .system_reset(sys_rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata));
   always #25 clk = ~clk;
   // Cycle ceiling against a hang; fails the run at 5000 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         bad_count++;
         test_done();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One single AHB-Lite transfer; read data lands in rd
   task automatic bus(input logic [31:0] a, input logic wr, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   // Registers and pins after a power-on with straps s
   task automatic check_strap(input logic [22:0] s);
      int g;
      while (sup_busy !== 1'b0 || sys_rst !== 1'b0) @(posedge clk);
      bus(FW_STRAP_ADDR, 1'b0, 32'h0);
      check(rd, {24'h0, s[14:7]});
      bus(FW_STRAP_ADDR, 1'b1, 32'hFF);
      bus(FW_STRAP_ADDR, 1'b0, 32'h0);
      check(rd, {24'h0, s[14:7]});
      bus(HW_STRAP_ADDR, 1'b0, 32'h0);
      check(rd, {24'h0, s[22:17], 2'h0});
      bus(STATUS_ADDR, 1'b0, 32'h0);
      check(rd, {30'h0, s[17], ~s[17]});
      bus(32'h3000_1C10, 1'b0, 32'h0);
      check(rd, 32'h0);
      bus(GATE_CTRL_ADDR, 1'b0, 32'h0);
      check(rd, {24'h0, GATE_CTRL_RESET});
      @(negedge clk);
      check({24'h0, in_only, pll_en, ext_clk, dbg_mode, sdram, boot_w, usb_en, pport_en},
         {24'h0, 1'b0, ~s[17], s[17], ~s[18], s[22], s[19], s[21], s[20]});
      for (g = 0; g < 4; g++) begin
         bus(GATE_CTRL_ADDR, 1'b1, 32'(g));
         @(negedge clk);
         check({30'h0, pport_en, usb_en}, {30'h0, s[20] & g[1], s[21] & g[0]});
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      check_strap(STRAP_A);
      // Second power-on with every strap inverted
      strap <= STRAP_B;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      repeat (4) @(negedge clk);
      check({28'h0, in_only, sys_rst, dbg_mode, ext_clk},
         {28'h0, 2'h3, ~STRAP_B[18], STRAP_B[17]});
      check_strap(STRAP_B);
      // Watchdog pulse while running
      n = 0;
      @(posedge clk);
      wdog_req <= 1'b1;
      @(posedge clk);
      wdog_req <= 1'b0;
      bus(STATUS_ADDR, 1'b0, 32'h0);
      check(rd, 32'h6);
      // Count the cycles of the pulse, one per falling edge
      while (sys_rst !== 1'b1) @(negedge clk);
      while (sys_rst !== 1'b0) begin
         @(negedge clk);
         n++;
      end
      check(32'(n >= 200 && n <= 206), 32'h1);
      // Divided clock and refresh tick over 480 cycles
      usb_prev = usb_12m;
      repeat (480) begin
         @(negedge clk);
         if (tick === 1'b1) ticks++;
         if (usb_12m === 1'b1 && usb_prev === 1'b0) rises++;
         usb_prev = usb_12m;
      end
      check(32'(ticks), 32'hA);
      check(32'(rises), 32'h78);
      test_done();
   end
endmodule
`default_nettype wire
